/* core/fcd_device.sv */
// flash command sequence decoder, device end
`timescale 1ns/1ps
module fcd_device
  import fcd_pkg::*;
(
  // clock and reset
  input  wire logic  clk,
  input  wire logic  reset,
  // command bus
  fcd_bus_if.dev     bus,
  // decoded operation
  output fcd_op_t             op,
  output logic                op_valid,
  output logic [ADDR_W-1:0]   op_addr,
  output logic [DATA_W-1:0]   op_data,
  // state
  output fcd_mode_t           mode,
  output logic                bypass,
  output logic                busy,
  output logic                suspended,
  output logic [DATA_W-1:0]   config_word_low,
  output logic [DATA_W-1:0]   config_word_high,
  // user side
  input  wire logic [DATA_W-1:0] array_rdata,
  input  wire logic              sector_locked,
  input  wire logic              timeout_flag_bit
);
  // ****************************************
  // pin synchronisers and edges
  // ****************************************
  logic [3:0] strb_s;
  logic [3:0] strb_d1_q;
  logic [ADDR_W-1:0] addr_s1_q, addr_s2_q;
  logic [DATA_W-1:0] data_s1_q, data_s2_q;

  fcd_sync #(.W(4)) u_sync (
    .clk     (clk),
    .reset   (reset),
    .din     ({bus.avd_n, bus.ce_n, bus.we_n, bus.oe_n}),
    .rst_val (4'hF),
    .dout    (strb_s)
  );

  always_ff @(posedge clk) begin
    addr_s1_q <= bus.addr;
    addr_s2_q <= addr_s1_q;
    data_s1_q <= bus.wdata;
    data_s2_q <= data_s1_q;
  end

  always_ff @(posedge clk) begin
    if (reset) strb_d1_q <= 4'hF;
    else       strb_d1_q <= strb_s;
  end

  logic avd_rise, we_rise, ce_rise, oe_fall;
  assign avd_rise = strb_s[3] & ~strb_d1_q[3];
  assign ce_rise  = strb_s[2] & ~strb_d1_q[2];
  assign we_rise  = strb_s[1] & ~strb_d1_q[1];
  assign oe_fall  = ~strb_s[0] & strb_d1_q[0] & ~strb_s[2];

  // address taken at avd rise or a clock while avd low, first wins
  logic [ADDR_W-1:0] cyc_addr_q;
  logic              addr_held_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      cyc_addr_q  <= '0;
      addr_held_q <= 1'b0;
    end else if (~strb_s[3] & ~addr_held_q) begin
      cyc_addr_q  <= addr_s2_q;
      addr_held_q <= 1'b1;
    end else if (avd_rise & ~addr_held_q) begin
      cyc_addr_q  <= addr_s2_q;
    end else if (strb_s[3] & (we_rise | ce_rise)) begin
      addr_held_q <= 1'b0;
    end
  end

  // write cycle completes on whichever of we or ce rises first
  logic wr_ev;
  logic [DATA_W-1:0] wd;
  assign wr_ev = (we_rise & ~strb_d1_q[2]) | (ce_rise & ~strb_d1_q[1]);
  assign wd    = data_s2_q;

  logic [10:0] ca;
  logic [7:0]  cd;
  assign ca = cyc_addr_q[CMD_ADDR_W-1:0];
  assign cd = wd[7:0];

  // ****************************************
  // sequence state
  // ****************************************
  typedef enum logic [3:0] {
    S_IDLE, S_U1, S_U2, S_PROG, S_E1, S_E2, S_E3, S_E4,
    S_BCNT, S_BDATA, S_BGO, S_CFG0, S_CFG1, S_BY_E, S_BY_X
  } fcd_seq_t;

  fcd_seq_t          seq_q;
  logic [5:0]        left_q;
  logic [5:0]        bcyc_q;
  logic [ADDR_W-1:0] sect_q;
  logic [DATA_W-1:0] cfg_lo_pend_q;
  logic [15:0]       busy_cnt_q;

  logic    go;
  fcd_op_t go_op;
  always_comb begin
    go    = 1'b0;
    go_op = OP_NONE;
    if (wr_ev) begin
      case (seq_q)
        S_PROG: begin go = 1'b1; go_op = OP_PROG; end
        S_E3: if (cd == C_CHIP || cd == C_SECTOR) begin
          go    = 1'b1;
          go_op = (cd == C_CHIP) ? OP_CHIP_ERASE : OP_SECT_ERASE;
        end
        S_BY_E: if (cd == C_CHIP || cd == C_SECTOR) begin
          go    = 1'b1;
          go_op = (cd == C_CHIP) ? OP_CHIP_ERASE : OP_SECT_ERASE;
        end
        S_BGO: if (cd == C_BUF_GO) begin go = 1'b1; go_op = OP_BUF_PROG; end
        S_CFG1: begin go = 1'b1; go_op = OP_CFG_SET; end
        S_IDLE: begin
          if (cd == C_SUSPEND && busy && !suspended) begin
            go = 1'b1; go_op = OP_SUSPEND;
          end else if (cd == C_RESUME && suspended) begin
            go = 1'b1; go_op = OP_RESUME;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      seq_q  <= S_IDLE;
      left_q <= '0;
      bcyc_q <= '0;
      sect_q <= '0;
    end else if (wr_ev) begin
      case (seq_q)
        S_IDLE: begin
          if (bypass) begin
            if (cd == C_PROG)       seq_q <= S_PROG;
            else if (cd == C_ERASE) seq_q <= S_BY_E;
            else if (cd == C_IDENT) seq_q <= S_BY_X;
            else if (cd == C_BUF_LOAD) begin
              seq_q  <= S_BCNT;
              sect_q <= cyc_addr_q;
              bcyc_q <= 6'd3;
            end
          end else if (cd == C_UNLOCK1 && ca == UNLOCK_A1) seq_q <= S_U1;
        end
        S_U1: seq_q <= (cd == C_UNLOCK2 && ca == UNLOCK_A2) ? S_U2 : S_IDLE;
        S_U2: begin
          seq_q <= S_IDLE;
          if (cd == C_PROG)       seq_q <= S_PROG;
          else if (cd == C_ERASE) seq_q <= S_E1;
          else if (cd == C_CFG_SET) seq_q <= S_CFG0;
          else if (cd == C_BUF_LOAD) begin
            seq_q  <= S_BCNT;
            sect_q <= cyc_addr_q;
            bcyc_q <= 6'd3;
          end
        end
        S_E1: seq_q <= (cd == C_UNLOCK1 && ca == UNLOCK_A1) ? S_E2 : S_IDLE;
        S_E2: seq_q <= (cd == C_UNLOCK2 && ca == UNLOCK_A2) ? S_E3 : S_IDLE;
        S_E3: seq_q <= S_IDLE;
        S_BCNT: begin
          left_q <= wd[5:0];
          bcyc_q <= bcyc_q + 6'd1;
          seq_q  <= (wd[5:0] < 6'(BUF_WORDS)) ? S_BDATA : S_IDLE;
        end
        S_BDATA: begin
          bcyc_q <= bcyc_q + 6'd1;
          if (left_q == '0) seq_q <= S_BGO;
          left_q <= left_q - 6'd1;
          if (bcyc_q >= 6'(MAX_BUF_CYC - 1)) seq_q <= S_IDLE;
        end
        S_CFG0: seq_q <= (ca[7:0] == 8'h00) ? S_CFG1 : S_IDLE;
        S_BY_X: seq_q <= S_IDLE;
        default: seq_q <= S_IDLE;
      endcase
    end
  end
  // sixth write is decoded in S_E3; a wrong final code drops to idle

  // ****************************************
  // mode, bypass, config and busy state
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      mode   <= MD_ARRAY;
      bypass <= 1'b0;
    end else if (wr_ev) begin
      if (seq_q == S_BY_X && cd == C_ZERO) bypass <= 1'b0;
      else if (seq_q == S_U2 && cd == C_BYPASS && ca == UNLOCK_A1)
        bypass <= 1'b1;
      if (!bypass && cd == C_RESET && seq_q inside {S_IDLE, S_U2})
        mode <= MD_ARRAY;
      else if (seq_q == S_U2 && cd == C_IDENT)  mode <= MD_IDENT;
      else if (seq_q == S_U2 && cd == C_CFG_READ) mode <= MD_CFG_READ;
      else if (cd == C_QUERY && (seq_q == S_IDLE)) mode <= MD_QUERY;
      else if (go && go_op != OP_SUSPEND && go_op != OP_CFG_SET)
        mode <= MD_STATUS;
    end else if (busy_cnt_q == 16'h0001 && mode == MD_STATUS
                 && !timeout_flag_bit) begin
      mode <= MD_ARRAY;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      config_word_low  <= CFG_RESET;
      config_word_high <= CFG_RESET;
      cfg_lo_pend_q    <= CFG_RESET;
    end else if (wr_ev && seq_q == S_CFG0 && ca[7:0] == 8'h00) begin
      cfg_lo_pend_q <= wd;
    end else if (wr_ev && seq_q == S_CFG1 && ca[7:0] == 8'h01) begin
      config_word_low  <= cfg_lo_pend_q;
      config_word_high <= wd;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      busy_cnt_q <= '0;
      suspended  <= 1'b0;
    end else if (go && go_op == OP_SUSPEND) begin
      suspended <= 1'b1;
    end else if (go && go_op == OP_RESUME) begin
      suspended <= 1'b0;
    end else if (go && go_op != OP_CFG_SET) begin
      busy_cnt_q <= BUSY_CYCLES;
    end else if (busy_cnt_q != '0 && !suspended) begin
      busy_cnt_q <= busy_cnt_q - 16'h0001;
    end
  end
  // registered so the output comes straight from a flop; one cycle late
  always_ff @(posedge clk) begin
    if (reset) busy <= 1'b0;
    else       busy <= (busy_cnt_q != '0);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      op       <= OP_NONE;
      op_valid <= 1'b0;
      op_addr  <= '0;
      op_data  <= '0;
    end else begin
      op_valid <= go;
      op       <= go ? go_op : OP_NONE;
      if (go) begin
        op_addr <= (go_op == OP_BUF_PROG) ? sect_q : cyc_addr_q;
        op_data <= wd;
      end
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      bus.rdata  <= '0;
      bus.rvalid <= 1'b0;
    end else begin
      bus.rvalid <= oe_fall;
      if (oe_fall) begin
        case (mode)
          MD_ARRAY:    bus.rdata <= array_rdata;
          MD_IDENT:    bus.rdata <= (cyc_addr_q[7:0] == ID_LOCK_OFS)
                         ? (sector_locked ? LOCK_SHUT : LOCK_OPEN)
                         : '0;
          MD_CFG_READ: bus.rdata <= cyc_addr_q[0] ? config_word_high
                                                  : config_word_low;
          MD_STATUS:   bus.rdata <= {10'h000, timeout_flag_bit, 5'h00};
          default:     bus.rdata <= '0;
        endcase
      end
    end
  end
endmodule : fcd_device

/* core/fcd_pkg.sv */
// constants and types shared by the flash command decoder ends
// Behaviour
// - program address latched at first strobe edge
// - program data latched at first write edge
// - command cycles are writes, listed reads excepted
// - data bits 15 to 8 ignored in commands
// - address bits 14 and up ignored in commands
// - host avoids bad cycles, resets after errors
// - array reads need no command cycles
// - reset command returns bank to read state; ignored while bypass is set
// - lock verify answers 0000h or 0001h
// - word count is locations minus one
// - buffer addresses stay in one page
// - buffer sequence at most 37 cycles
// - bypass entry is AA, 55, 20 writes
// - short bypass commands only after entry
// - bypass erase 80 then 30/10, 98 query
// - bypass left only by 90 then 00
// - buffer program allowed inside bypass mode
// - B0 suspends running program or erase only
// - 30 resumes only while suspended
// - host never writes 30h as config data
// - config read mode held until reset
// - config low word before high, else kept
package fcd_pkg;
  // ****************************************
  // bus widths and codes
  // ****************************************
  localparam int unsigned ADDR_W       = 24;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned CMD_ADDR_W   = 11;
  localparam int unsigned BUF_WORDS    = 32;
  localparam int unsigned MAX_BUF_CYC  = 37;
  localparam logic [10:0] UNLOCK_A1    = 11'h555;
  localparam logic [10:0] UNLOCK_A2    = 11'h2AA;
  localparam logic [10:0] QUERY_A      = 11'h055;
  localparam logic [7:0]  C_UNLOCK1    = 8'hAA;
  localparam logic [7:0]  C_UNLOCK2    = 8'h55;
  localparam logic [7:0]  C_RESET      = 8'hF0;
  localparam logic [7:0]  C_IDENT      = 8'h90;
  localparam logic [7:0]  C_PROG       = 8'hA0;
  localparam logic [7:0]  C_BUF_LOAD   = 8'h25;
  localparam logic [7:0]  C_BUF_GO     = 8'h29;
  localparam logic [7:0]  C_ERASE      = 8'h80;
  localparam logic [7:0]  C_CHIP       = 8'h10;
  localparam logic [7:0]  C_SECTOR     = 8'h30;
  localparam logic [7:0]  C_SUSPEND    = 8'hB0;
  localparam logic [7:0]  C_RESUME     = 8'h30;
  localparam logic [7:0]  C_CFG_SET    = 8'hD0;
  localparam logic [7:0]  C_CFG_READ   = 8'hC6;
  localparam logic [7:0]  C_QUERY      = 8'h98;
  localparam logic [7:0]  C_BYPASS     = 8'h20;
  localparam logic [7:0]  C_ZERO       = 8'h00;
  localparam logic [15:0] LOCK_OPEN    = 16'h0000;
  localparam logic [15:0] LOCK_SHUT    = 16'h0001;
  localparam logic [7:0]  ID_LOCK_OFS  = 8'h02;
  localparam logic [15:0] CFG_RESET    = 16'h0000;
  localparam logic [15:0] BUSY_CYCLES  = 16'h0040;

  // ****************************************
  // operations and modes
  // ****************************************
  typedef enum logic [3:0] {
    OP_NONE, OP_PROG, OP_BUF_PROG, OP_CHIP_ERASE, OP_SECT_ERASE,
    OP_SUSPEND, OP_RESUME, OP_CFG_SET, OP_ABORT
  } fcd_op_t;

  typedef enum logic [2:0] {
    MD_ARRAY, MD_IDENT, MD_CFG_READ, MD_QUERY, MD_STATUS
  } fcd_mode_t;
endpackage : fcd_pkg

/* core/fcd_bus_if.sv */
// command bus between host controller and flash decoder
`timescale 1ns/1ps
interface fcd_bus_if;
  import fcd_pkg::*;
  logic              avd_n;
  logic              ce_n;
  logic              we_n;
  logic              oe_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              rvalid;

  modport dev  (input avd_n, ce_n, we_n, oe_n, addr, wdata,
                output rdata, rvalid);
  modport host (output avd_n, ce_n, we_n, oe_n, addr, wdata,
                input rdata, rvalid);
endinterface : fcd_bus_if

/* core/fcd_sync.sv */
// two-flop synchroniser for the strobe pins
`timescale 1ns/1ps
module fcd_sync #(
  parameter int unsigned W = 4
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= '1;
      dout   <= '1;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
  logic unused_rst;
  assign unused_rst = |rst_val;
endmodule : fcd_sync

/* core/fcd_host.sv */
// flash command sequence decoder, host controller end
`timescale 1ns/1ps
module fcd_host
  import fcd_pkg::*;
(
  // clock and reset
  input  wire logic  clk,
  input  wire logic  reset,
  // command bus
  fcd_bus_if.host    bus,
  // user request
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_data,
  output logic                   req_ready,
  // read answer
  output logic [DATA_W-1:0]      rsp_data,
  output logic                   rsp_valid
);
  // one bus cycle per request; user sequences commands, obeys order
  // are the user's duty; this end just shapes the strobes
  localparam logic [2:0] PH_LAST = 3'd5;
  logic [2:0] ph_q;
  logic       wr_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      ph_q      <= '0;
      wr_q      <= 1'b0;
      req_ready <= 1'b1;
      bus.avd_n <= 1'b1;
      bus.ce_n  <= 1'b1;
      bus.we_n  <= 1'b1;
      bus.oe_n  <= 1'b1;
      bus.addr  <= '0;
      bus.wdata <= '0;
    end else if (ph_q == '0) begin
      if (req_valid && req_ready) begin
        ph_q      <= 3'd1;
        wr_q      <= req_write;
        req_ready <= 1'b0;
        bus.addr  <= req_addr;
        bus.wdata <= req_data;
        bus.ce_n  <= 1'b0;
        bus.avd_n <= 1'b0;
      end
    end else begin
      ph_q <= (ph_q == PH_LAST) ? 3'd0 : ph_q + 3'd1;
      case (ph_q)
        3'd1: begin
          bus.avd_n <= 1'b1;
          if (wr_q) bus.we_n <= 1'b0;
          else      bus.oe_n <= 1'b0;
        end
        3'd4: begin
          bus.we_n <= 1'b1;
          bus.oe_n <= 1'b1;
        end
        3'd5: begin
          bus.ce_n  <= 1'b1;
          req_ready <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_data  <= '0;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= bus.rvalid;
      if (bus.rvalid) rsp_data <= bus.rdata;
    end
  end
endmodule : fcd_host

/* test/fcd_bus_properties.sv */
// concurrent checks on the flash command bus between the two ends
`timescale 1ns/1ps
module fcd_bus_properties
  import fcd_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              reset,
  // command bus
  input wire logic              avd_n,
  input wire logic              ce_n,
  input wire logic              we_n,
  input wire logic              oe_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              rvalid
);
  // ********************
  // bus timing
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_strobe_excl :
    assert property (we_n || oe_n) else $error("read and write together");
  a_write_selected :
    assert property (!we_n |-> !ce_n) else $error("write while deselected");
  a_addr_strobe_one :
    assert property ($fell(avd_n) |-> !ce_n ##1 avd_n)
    else $error("address strobe not a one cycle pulse");
  a_addr_held :
    assert property ((!ce_n && $past(!ce_n)) |-> $stable(addr))
    else $error("address moved inside a bus cycle");
  a_write_width :
    assert property ($fell(we_n) |-> !we_n [*3] ##1 we_n)
    else $error("write strobe width wrong");
  a_data_held :
    assert property (!we_n |-> $stable(wdata))
    else $error("write data moved under the strobe");
  a_select_release :
    assert property ($rose(we_n) |=> ce_n)
    else $error("chip select not released after write");
  a_read_answer :
    assert property ($fell(oe_n) |-> ##[1:8] rvalid)
    else $error("read not answered");
  a_answer_pulse :
    assert property (rvalid |=> !rvalid) else $error("answer not a pulse");

  c_write : cover property ($fell(we_n));
  c_read : cover property ($fell(oe_n) ##[1:8] rvalid);
  c_strobe : cover property ($fell(avd_n));
endmodule : fcd_bus_properties

/* test/testbench.sv */
// self-checking bench joining host and device ends of the decoder
`timescale 1ns/1ps
module testbench;
  import fcd_pkg::*;
  // ********************
  // signals
  // ********************
  logic              clk;
  logic              reset;
  logic              req_valid;
  logic              req_write;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_data;
  logic              req_ready;
  logic [DATA_W-1:0] rsp_data;
  logic              rsp_valid;
  fcd_op_t           op;
  logic              op_valid;
  logic [ADDR_W-1:0] op_addr;
  logic [DATA_W-1:0] op_data;
  fcd_mode_t         mode;
  logic              bypass;
  logic              busy;
  logic              suspended;
  logic [DATA_W-1:0] cfg_lo;
  logic [DATA_W-1:0] cfg_hi;
  logic [DATA_W-1:0] array_rdata;
  logic              sector_locked;
  logic              timeout_flag_bit;
  int                errors;
  int                n_checks;
  int                cyc = 0;
  int                n;
  logic [3:0]        exp_q[$];
  logic [3:0]        got_q[$];
  logic [ADDR_W-1:0] pa;
  logic [DATA_W-1:0] pd;

  fcd_bus_if fcd_bus_if_inst ();
  fcd_host fcd_host_inst (.clk(clk), .reset(reset), .bus(fcd_bus_if_inst),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_data(req_data), .req_ready(req_ready), .rsp_data(rsp_data),
    .rsp_valid(rsp_valid));
  fcd_device fcd_device_inst (.clk(clk), .reset(reset),
    .bus(fcd_bus_if_inst), .op(op), .op_valid(op_valid),
    .op_addr(op_addr), .op_data(op_data), .mode(mode), .bypass(bypass),
    .busy(busy), .suspended(suspended), .config_word_low(cfg_lo),
    .config_word_high(cfg_hi), .array_rdata(array_rdata),
    .sector_locked(sector_locked), .timeout_flag_bit(timeout_flag_bit));
  fcd_bus_properties fcd_bus_properties_inst (.clk(clk), .reset(reset),
    .avd_n(fcd_bus_if_inst.avd_n), .ce_n(fcd_bus_if_inst.ce_n),
    .we_n(fcd_bus_if_inst.we_n), .oe_n(fcd_bus_if_inst.oe_n),
    .addr(fcd_bus_if_inst.addr), .wdata(fcd_bus_if_inst.wdata),
    .rdata(fcd_bus_if_inst.rdata), .rvalid(fcd_bus_if_inst.rvalid));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // op monitor and hang guard
  always @(posedge clk) begin
    if (op_valid === 1'b1) got_q.push_back(op);
    cyc++;
    if (cyc == 60000) begin
      errors++;
      results();
    end
  end

  // ********************
  // tasks
  // ********************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // ready is looked at on the falling edge, where it is settled;
  // the next rising edge then takes the request
  task automatic bw(input logic [23:0] a, input logic [15:0] d,
                    input logic w);
    int i;
    i = 0;
    req_valid = 1'b1;
    req_write = w;
    req_addr  = a;
    req_data  = d;
    while (req_ready !== 1'b1 && i < 100) begin
      @(negedge clk);
      i++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    @(negedge clk);
  endtask : bw

  // high address and data bits are noise in command cycles
  task automatic cmd(input logic [10:0] a, input logic [7:0] d);
    bw({10'($urandom), 3'b000, a}, {8'($urandom), d}, 1'b1);
  endtask : cmd

  task automatic unl(input logic [7:0] d);
    cmd(UNLOCK_A1, C_UNLOCK1);
    cmd(UNLOCK_A2, C_UNLOCK2);
    cmd(UNLOCK_A1, d);
  endtask : unl

  task automatic settle;
    int i;
    i = 0;
    while (req_ready !== 1'b1 && i < 100) begin
      @(negedge clk);
      i++;
    end
    repeat (6) @(negedge clk);
  endtask : settle

  task automatic idle;
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 2000) begin
      @(negedge clk);
      i++;
    end
  endtask : idle

  task automatic br(input logic [23:0] a, input logic [15:0] e);
    int i;
    i = 0;
    bw(a, 16'h0000, 1'b0);
    while (rsp_valid !== 1'b1 && i < 50) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk(rsp_data, e);
    @(negedge clk);
  endtask : br

  task automatic ops_chk;
    settle();
    chk(got_q.size(), exp_q.size());
    while (exp_q.size() > 0 && got_q.size() > 0)
      chk(got_q.pop_front(), exp_q.pop_front());
    exp_q.delete();
    got_q.delete();
  endtask : ops_chk

  task automatic results;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  // ********************
  // sequence
  // ********************
  initial begin
    reset = 1'b1;
    {req_valid, req_write, req_addr, req_data} = '0;
    {array_rdata, sector_locked, timeout_flag_bit} = '0;
    errors = 0;
    n_checks = 0;
    void'($urandom(18));
    repeat (5) @(negedge clk);
    reset = 1'b0;
    chk(mode, MD_ARRAY);
    chk({bypass, cfg_lo, cfg_hi}, {1'b0, CFG_RESET, CFG_RESET});
    array_rdata = 16'($urandom);
    br({10'($urandom), 14'h0123}, array_rdata);
    pa = 24'($urandom);
    pd = 16'($urandom);
    unl(C_PROG);
    bw(pa, pd, 1'b1);
    exp_q.push_back(OP_PROG);
    ops_chk();
    chk({op_addr, op_data}, {pa, pd});
    idle();
    cmd(11'h000, C_SUSPEND);
    ops_chk();
    unl(C_PROG);
    bw(pa, pd, 1'b1);
    cmd(11'h000, C_SUSPEND);
    exp_q = '{OP_PROG, OP_SUSPEND};
    ops_chk();
    chk(suspended, 1'b1);
    cmd(11'h000, C_RESUME);
    exp_q.push_back(OP_RESUME);
    ops_chk();
    chk(suspended, 1'b0);
    idle();
    cmd(11'h000, C_RESUME);
    ops_chk();
    for (int k = 0; k < 2; k++) begin
      idle();
      unl(C_ERASE);
      cmd(UNLOCK_A1, C_UNLOCK1);
      cmd(UNLOCK_A2, C_UNLOCK2);
      if (k == 1) cmd(11'h000, C_SECTOR);
      else cmd(UNLOCK_A1, C_CHIP);
      exp_q.push_back(k == 1 ? OP_SECT_ERASE : OP_CHIP_ERASE);
      ops_chk();
    end
    // full buffer first, then a random load; one page, at most 37 cycles
    for (int k = 0; k < 2; k++) begin
      idle();
      n = (k == 0) ? 32 : 1 + $urandom % 31;
      pa = {10'($urandom), 14'h0000};
      cmd(UNLOCK_A1, C_UNLOCK1);
      cmd(UNLOCK_A2, C_UNLOCK2);
      bw(pa, {8'h00, C_BUF_LOAD}, 1'b1);
      bw(pa, 16'(n - 1), 1'b1);
      for (int i = 0; i < n; i++) bw(pa | 24'(i), 16'($urandom), 1'b1);
      bw(pa, {8'h00, C_BUF_GO}, 1'b1);
      exp_q.push_back(OP_BUF_PROG);
      ops_chk();
    end
    idle();
    unl(C_BYPASS);
    settle();
    chk(bypass, 1'b1);
    cmd(11'h000, C_PROG);
    bw(pa, pd, 1'b1);
    exp_q.push_back(OP_PROG);
    ops_chk();
    for (int k = 0; k < 2; k++) begin
      idle();
      cmd(11'h000, C_ERASE);
      cmd(11'h000, k == 1 ? C_SECTOR : C_CHIP);
      exp_q.push_back(k == 1 ? OP_SECT_ERASE : OP_CHIP_ERASE);
      ops_chk();
    end
    idle();
    cmd(11'h000, C_QUERY);
    settle();
    chk(mode, MD_QUERY);
    cmd(11'h000, C_RESET);
    settle();
    chk(bypass, 1'b1);
    cmd(11'h000, C_IDENT);
    cmd(11'h000, C_ZERO);
    settle();
    chk(bypass, 1'b0);
    cmd(11'h000, C_RESET);
    settle();
    chk(mode, MD_ARRAY);
    cmd(11'h000, C_PROG);
    bw(pa, pd, 1'b1);
    ops_chk();
    // top bit set keeps config words off 0030h; their low byte, the one decoded, stays random
    pa = {8'h00, 16'($urandom) | 16'h8000};
    pd = 16'($urandom) | 16'h8000;
    unl(C_CFG_SET);
    bw({10'($urandom), 14'h0000}, pa[15:0], 1'b1);
    bw({10'($urandom), 14'h0001}, pd, 1'b1);
    settle();
    chk({cfg_lo, cfg_hi}, {pa[15:0], pd});
    unl(C_CFG_SET);
    bw({10'($urandom), 14'h0001}, ~pd, 1'b1);
    bw({10'($urandom), 14'h0000}, ~pa[15:0], 1'b1);
    settle();
    chk({cfg_lo, cfg_hi}, {pa[15:0], pd});
    cmd(11'h000, C_RESET);
    unl(C_CFG_READ);
    br({10'($urandom), 14'h0000}, pa[15:0]);
    br({10'($urandom), 14'h0001}, pd);
    chk(mode, MD_CFG_READ);
    cmd(11'h000, C_RESET);
    settle();
    chk(mode, MD_ARRAY);
    for (int k = 0; k < 2; k++) begin
      sector_locked = k[0];
      unl(C_IDENT);
      br({10'($urandom), 6'h00, ID_LOCK_OFS}, k ? LOCK_SHUT : LOCK_OPEN);
      chk(mode, MD_IDENT);
      cmd(11'h000, C_RESET);
      settle();
      chk(mode, MD_ARRAY);
    end
    results();
  end
endmodule : testbench
